//--- clock_select_pkg.sv
// constants, field layouts and types shared by the system clock selection block
package clock_select_pkg;

   // ************************************************
   // register port geometry
   // ************************************************
   localparam int                DATA_W               = 8;
   localparam int                ADDR_W               = 2;
   localparam logic [ADDR_W-1:0] SYS_CLK_CTRL_ADDR    = 2'h0;
   localparam logic [ADDR_W-1:0] FAST_OSC_CTRL_ADDR   = 2'h1;
   localparam logic [ADDR_W-1:0] PERIPH_CLK_CTRL_ADDR = 2'h2;

   // ************************************************
   // system_clock_control layout
   // ************************************************
   localparam int SEL_LSB       = 5;
   localparam int SEL_MSB       = 7;
   localparam int IDLE_FAST_BIT = 1;
   localparam int IDLE_SLOW_BIT = 0;

   // ************************************************
   // fast oscillator control layout
   // ************************************************
   localparam int FREQ_LSB   = 2;
   localparam int FREQ_MSB   = 3;
   localparam int STABLE_BIT = 1;
   localparam int ENABLE_BIT = 0;

   // ************************************************
   // peripheral clock control layout
   // ************************************************
   localparam int TB_SRC_BIT = 0;

   // ************************************************
   // selection and frequency codes
   // ************************************************
   localparam int               SEL_W      = 3;
   localparam int               FREQ_W     = 2;
   localparam int               DIV_STAGES = 6;
   localparam logic [SEL_W-1:0] SEL_FAST   = 3'h0;
   localparam logic [SEL_W-1:0] SEL_SLOW   = 3'h7;
   localparam logic [FREQ_W-1:0] FREQ_2MHZ     = 2'h0;
   localparam logic [FREQ_W-1:0] FREQ_4MHZ     = 2'h1;
   localparam logic [FREQ_W-1:0] FREQ_8MHZ     = 2'h2;
   localparam logic [FREQ_W-1:0] FREQ_2MHZ_ALT = 2'h3;

   // ************************************************
   // reset values
   // ************************************************
   localparam logic [SEL_W-1:0]  SEL_RST       = 3'h0;
   localparam logic [FREQ_W-1:0] FREQ_RST      = 2'h0;
   localparam logic              FAST_EN_RST   = 1'b1;
   localparam logic              IDLE_FAST_RST = 1'b0;
   localparam logic              IDLE_SLOW_RST = 1'b0;
   localparam logic              TB_SRC_RST    = 1'b0;

   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_PERIOD_NS  = 100;
   localparam int SETTLE_TIME_NS = 16000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef enum logic [1:0] {
      OSC_OFF    = 2'b00,
      OSC_SETTLE = 2'b01,
      OSC_STABLE = 2'b10
   } osc_state_t;

   // both 2 MHz codes drive the oscillator with one trim code
   function automatic logic [FREQ_W-1:0] norm_freq(input logic [FREQ_W-1:0] code);
      norm_freq = (code == FREQ_2MHZ_ALT) ? FREQ_2MHZ : code;
   endfunction : norm_freq

endpackage : clock_select_pkg

//--- fast_clock_divider.sv
// ripple-free divider producing the fast clock and its binary divisions
`timescale 1ns/1ps
module fast_clock_divider
   import clock_select_pkg::*;
#(
   parameter int STAGES = DIV_STAGES
) (
   input  wire logic              clock_in,
   input  wire logic              srst_in,
   input  wire logic              fast_lvl_in,
   input  wire logic              gate_in,
   output logic      [STAGES:0]   taps_out
);

   logic              prev_q;
   logic [STAGES-1:0] count_q;
   logic              rise;

   assign rise = fast_lvl_in & ~prev_q;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= fast_lvl_in;
      end
   end

   // RULE_02: divide by two per stage
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         count_q <= '0;
      end else if (rise && gate_in) begin
         count_q <= count_q + 1'b1;
      end
   end

   // tap 0 undivided, tap k divided by two to the k
   assign taps_out = {count_q, fast_lvl_in & gate_in};

   a_div_count_step : assert property (@(posedge clock_in) disable iff (srst_in)
      (rise && gate_in) |=> count_q == $past(count_q) + 1'b1) // RULE_02
      else $error("divider did not step on a fast clock edge");

   a_div_gate_hold : assert property (@(posedge clock_in) disable iff (srst_in)
      !gate_in |=> count_q == $past(count_q)) // RULE_08
      else $error("divider advanced while the oscillator was unstable");

endmodule : fast_clock_divider

//--- glitch_free_clock_mux.sv
// source selector that only hands over while both clocks are low
`timescale 1ns/1ps
module glitch_free_clock_mux
   import clock_select_pkg::*;
#(
   parameter int N = 8
) (
   input  wire logic               clock_in,
   input  wire logic               srst_in,
   input  wire logic [N-1:0]       src_in,
   input  wire logic [SEL_W-1:0]   sel_in,
   output logic      [SEL_W-1:0]   active_sel_out,
   output logic                    clk_out
);

   logic [SEL_W-1:0] active_q;
   logic             clk_q;
   logic             handover_ok;

   // both low: the old pulse has ended and the new one has not begun
   assign handover_ok = (sel_in != active_q) && !src_in[active_q] && !src_in[sel_in];

   // RULE_10: hand over only in a common low phase
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         active_q <= SEL_RST;
      end else if (handover_ok) begin
         active_q <= sel_in;
      end
   end

   // RULE_01: system clock follows the active source
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         clk_q <= 1'b0;
      end else begin
         clk_q <= src_in[active_q];
      end
   end

   assign active_sel_out = active_q;
   assign clk_out        = clk_q;

   a_mux_switch_low : assert property (@(posedge clock_in) disable iff (srst_in)
      (active_q != $past(active_q)) |-> !clk_q && !$past(src_in[sel_in])) // RULE_10
      else $error("clock source changed while the output was high");

endmodule : glitch_free_clock_mux

//--- system_clock_source_select.sv
// system clock source selection, fast oscillator control and peripheral clocks
`timescale 1ns/1ps
import clock_select_pkg::*;

// Function
// RULE_01: the system clock is taken from the fast or slow clock by a three-bit field, changeable at run time.
// RULE_02: the field also offers the fast clock divided by 2 up to 64.
// RULE_03: the fast clock comes from an internal oscillator at 2, 4 or 8 MHz.
// RULE_04: the slow clock comes from an internal 32 kHz oscillator.
// RULE_05: after moving to the slow clock the fast oscillator stops or keeps running as its enable bit says.
// RULE_06: the oscillators also clock the watchdog and the time base.
// RULE_07: codes 000 to 110 give the fast clock divided by 1 to 64, code 111 the slow clock.
// RULE_08: the frequency field gives 2 MHz for 00 and 11, 4 MHz for 01, 8 MHz for 10, applied once stable.
// RULE_09: enabling the fast oscillator clears the stable flag, which sets once the oscillator settles.
// RULE_10: source changes make no truncated pulse or glitch on the system clock.
module system_clock_source_select
   import clock_select_pkg::*;
#(
   parameter int SETTLE_NS = SETTLE_TIME_NS
) (
   input  wire logic                clock_in,
   input  wire logic                srst_in,
   input  wire reg_req_t            reg_req_in,
   input  wire logic                fast_osc_pin_in,
   input  wire logic                slow_osc_pin_in,
   output logic      [DATA_W-1:0]   rd_data_out,
   output logic                     fast_osc_run_out,
   output logic      [FREQ_W-1:0]   fast_osc_freq_out,
   output logic                     fast_osc_stable_out,
   output logic                     system_clock_out,
   output logic      [DIV_STAGES:0] fast_periph_clock_out,
   output logic                     wdt_clock_out,
   output logic                     time_base_clock_out,
   output logic                     idle_fast_en_out,
   output logic                     idle_slow_en_out
);

   // least time rounds up to whole cycles
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic fast_meta_q;
   logic fast_sync_q;
   logic slow_meta_q;
   logic slow_sync_q;

   // RULE_03: fast oscillator output enters the clock domain
   // RULE_04: slow oscillator output enters the clock domain
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         fast_meta_q <= 1'b0;
         fast_sync_q <= 1'b0;
         slow_meta_q <= 1'b0;
         slow_sync_q <= 1'b0;
      end else begin
         fast_meta_q <= fast_osc_pin_in;
         fast_sync_q <= fast_meta_q;
         slow_meta_q <= slow_osc_pin_in;
         slow_sync_q <= slow_meta_q;
      end
   end

   // ************************************************
   // control registers
   // ************************************************
   logic [SEL_W-1:0]  sel_q;
   logic [FREQ_W-1:0] freq_q;
   logic              fast_en_q;
   logic              idle_fast_q;
   logic              idle_slow_q;
   logic              tb_src_q;
   logic              wr_sys;
   logic              wr_fast;
   logic              wr_periph;

   assign wr_sys    = reg_req_in.wr && (reg_req_in.addr == SYS_CLK_CTRL_ADDR);
   assign wr_fast   = reg_req_in.wr && (reg_req_in.addr == FAST_OSC_CTRL_ADDR);
   assign wr_periph = reg_req_in.wr && (reg_req_in.addr == PERIPH_CLK_CTRL_ADDR);

   // RULE_01: selection may be rewritten at any time
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         sel_q       <= SEL_RST;
         idle_fast_q <= IDLE_FAST_RST;
         idle_slow_q <= IDLE_SLOW_RST;
      end else if (wr_sys) begin
         sel_q       <= reg_req_in.wdata[SEL_MSB:SEL_LSB];
         idle_fast_q <= reg_req_in.wdata[IDLE_FAST_BIT];
         idle_slow_q <= reg_req_in.wdata[IDLE_SLOW_BIT];
      end
   end

   // stable bit is read-only, writes to it are dropped
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         freq_q    <= FREQ_RST;
         fast_en_q <= FAST_EN_RST;
      end else if (wr_fast) begin
         freq_q    <= reg_req_in.wdata[FREQ_MSB:FREQ_LSB];
         fast_en_q <= reg_req_in.wdata[ENABLE_BIT];
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tb_src_q <= TB_SRC_RST;
      end else if (wr_periph) begin
         tb_src_q <= reg_req_in.wdata[TB_SRC_BIT];
      end
   end

   // ************************************************
   // fast oscillator run and settle tracking
   // ************************************************
   osc_state_t        osc_state_q;
   logic [CNT_W-1:0]  settle_cnt_q;
   logic              stable_q;
   logic              run_d;
   logic              run_q;
   logic              restart;
   logic [SEL_W-1:0]  active_sel;
   logic [FREQ_W-1:0] freq_out_q;

   // RULE_05: oscillator needed while the system uses it, else by its enable bit
   assign run_d = fast_en_q || (sel_q != SEL_SLOW) || (active_sel != SEL_SLOW);

   // RULE_09: re-enable or a new frequency forces a fresh settle
   assign restart = wr_fast &&
                    ((reg_req_in.wdata[ENABLE_BIT] && !fast_en_q) ||
                     (reg_req_in.wdata[FREQ_MSB:FREQ_LSB] != freq_q));

   // RULE_09: clear on start, set after the settle time
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         osc_state_q  <= OSC_OFF;
         settle_cnt_q <= '0;
      end else begin
         unique case (osc_state_q)
            OSC_OFF: begin
               settle_cnt_q <= '0;
               if (run_d) begin
                  osc_state_q <= OSC_SETTLE;
               end
            end
            OSC_SETTLE: begin
               if (!run_d) begin
                  osc_state_q  <= OSC_OFF;
                  settle_cnt_q <= '0;
               end else if (restart) begin
                  settle_cnt_q <= '0;
               end else if (settle_cnt_q == SETTLE_LAST) begin
                  osc_state_q  <= OSC_STABLE;
               end else begin
                  settle_cnt_q <= settle_cnt_q + 1'b1;
               end
            end
            OSC_STABLE: begin
               settle_cnt_q <= '0;
               if (!run_d) begin
                  osc_state_q <= OSC_OFF;
               end else if (restart) begin
                  osc_state_q <= OSC_SETTLE;
               end
            end
            default: begin
               osc_state_q  <= OSC_OFF;
               settle_cnt_q <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         stable_q <= 1'b0;
      end else if (restart || !run_d) begin
         stable_q <= 1'b0;
      end else begin
         stable_q <= (osc_state_q == OSC_SETTLE && settle_cnt_q == SETTLE_LAST) ||
                     (osc_state_q == OSC_STABLE);
      end
   end

   // RULE_08: both 2 MHz codes map to one oscillator setting
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         run_q      <= FAST_EN_RST;
         freq_out_q <= FREQ_RST;
      end else begin
         run_q      <= run_d;
         freq_out_q <= norm_freq(freq_q);
      end
   end

   // ************************************************
   // division and source selection
   // ************************************************
   logic [DIV_STAGES:0] taps;
   logic                sys_clk;

   // RULE_08: an unstable oscillator feeds no clock downstream
   fast_clock_divider #(
      .STAGES      (DIV_STAGES)
   ) u_divider (
      .clock_in    (clock_in),
      .srst_in     (srst_in),
      .fast_lvl_in (fast_sync_q),
      .gate_in     (stable_q),
      .taps_out    (taps)
   );

   // RULE_07: index 0..6 are the fast divisions, 7 is the slow clock
   glitch_free_clock_mux #(
      .N              (DIV_STAGES + 2)
   ) u_mux (
      .clock_in       (clock_in),
      .srst_in        (srst_in),
      .src_in         ({slow_sync_q, taps}),
      .sel_in         (sel_q),
      .active_sel_out (active_sel),
      .clk_out        (sys_clk)
   );

   // ************************************************
   // peripheral clocks and read port
   // ************************************************
   logic [DIV_STAGES:0] periph_q;
   logic                wdt_q;
   logic                tb_q;
   logic [DATA_W-1:0]   rd_data_q;
   logic [DATA_W-1:0]   rd_word;

   // RULE_05: divided fast clocks stay up for peripherals only while it runs
   // RULE_06: watchdog always on the slow clock, time base selectable
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         periph_q <= '0;
         wdt_q    <= 1'b0;
         tb_q     <= 1'b0;
      end else begin
         periph_q <= run_q ? taps : '0;
         wdt_q    <= slow_sync_q;
         tb_q     <= tb_src_q ? taps[DIV_STAGES] : slow_sync_q;
      end
   end

   always_comb begin
      rd_word = '0;
      unique case (reg_req_in.addr)
         SYS_CLK_CTRL_ADDR: begin
            rd_word[SEL_MSB:SEL_LSB] = sel_q;
            rd_word[IDLE_FAST_BIT]   = idle_fast_q;
            rd_word[IDLE_SLOW_BIT]   = idle_slow_q;
         end
         FAST_OSC_CTRL_ADDR: begin
            rd_word[FREQ_MSB:FREQ_LSB] = freq_q;
            rd_word[STABLE_BIT]        = stable_q;
            rd_word[ENABLE_BIT]        = fast_en_q;
         end
         PERIPH_CLK_CTRL_ADDR: begin
            rd_word[TB_SRC_BIT] = tb_src_q;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // data only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= reg_req_in.rd ? rd_word : '0;
      end
   end

   assign rd_data_out           = rd_data_q;
   assign fast_osc_run_out      = run_q;
   assign fast_osc_freq_out     = freq_out_q;
   assign fast_osc_stable_out   = stable_q;
   assign system_clock_out      = sys_clk;
   assign fast_periph_clock_out = periph_q;
   assign wdt_clock_out         = wdt_q;
   assign time_base_clock_out   = tb_q;
   assign idle_fast_en_out      = idle_fast_q;
   assign idle_slow_en_out      = idle_slow_q;

   // ************************************************
   // checks
   // ************************************************
   a_sel_write_takes : assert property (@(posedge clock_in) disable iff (srst_in)
      wr_sys |=> sel_q == $past(reg_req_in.wdata[SEL_MSB:SEL_LSB])) // RULE_01
      else $error("clock selection write was not stored");

   a_slow_code_route : assert property (@(posedge clock_in) disable iff (srst_in)
      (active_sel == SEL_SLOW && $past(active_sel) == SEL_SLOW)
      |-> sys_clk == $past(slow_sync_q)) // RULE_07
      else $error("code 111 does not route the slow clock");

   a_fast_code_route : assert property (@(posedge clock_in) disable iff (srst_in)
      (active_sel == SEL_FAST && $past(active_sel) == SEL_FAST)
      |-> sys_clk == $past(fast_sync_q && stable_q)) // RULE_07
      else $error("code 000 does not route the undivided fast clock");

   a_freq_alias_2m : assert property (@(posedge clock_in) disable iff (srst_in)
      freq_q == FREQ_2MHZ_ALT |=> fast_osc_freq_out == FREQ_2MHZ) // RULE_08
      else $error("frequency code 11 did not select 2 MHz");

   a_enable_clears : assert property (@(posedge clock_in) disable iff (srst_in)
      (wr_fast && reg_req_in.wdata[ENABLE_BIT] && !fast_en_q) |=> !stable_q) // RULE_09
      else $error("stable flag not cleared when the oscillator was enabled");

   a_settle_sets : assert property (@(posedge clock_in) disable iff (srst_in)
      (osc_state_q == OSC_SETTLE && settle_cnt_q == SETTLE_LAST && run_d && !restart)
      |=> stable_q && osc_state_q == OSC_STABLE) // RULE_09
      else $error("stable flag not set at the end of the settle time");

   a_fast_stops : assert property (@(posedge clock_in) disable iff (srst_in)
      (!fast_en_q && sel_q == SEL_SLOW && active_sel == SEL_SLOW)
      |=> !fast_osc_run_out ##1 fast_periph_clock_out == '0) // RULE_05
      else $error("fast oscillator kept running with its enable clear");

   a_fast_keeps : assert property (@(posedge clock_in) disable iff (srst_in)
      fast_en_q |=> fast_osc_run_out) // RULE_05
      else $error("fast oscillator stopped while enabled");

   a_wdt_slow_src : assert property (@(posedge clock_in) disable iff (srst_in)
      $rose(slow_sync_q) |=> wdt_clock_out && ($past(tb_src_q) || time_base_clock_out)) // RULE_06
      else $error("watchdog clock does not follow the slow clock");

endmodule : system_clock_source_select

//--- testbench.sv
// self-checking bench for the system clock source selection block
`timescale 1ns/1ps
module testbench;
   import clock_select_pkg::*;

   // ************************************************
   // signals and design
   // ************************************************
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
   } row_t;

   logic                clock_in;
   logic                srst_in;
   reg_req_t            req;
   logic                fast_pin;
   logic                slow_pin;
   logic [DATA_W-1:0]   rd_data_out;
   logic                fast_osc_run_out;
   logic [FREQ_W-1:0]   fast_osc_freq_out;
   logic                fast_osc_stable_out;
   logic                system_clock_out;
   logic [DIV_STAGES:0] fast_periph_clock_out;
   logic                wdt_clock_out;
   logic                time_base_clock_out;
   logic                idle_fast_en_out;
   logic                idle_slow_en_out;
   int                  mismatches;
   int                  compares;
   int                  cycles;
   int                  pcnt;
   int                  high_run;
   logic                glitch_mon;
   logic [7:0]          rd;
   int                  n;
   row_t                rows[6];

   // short settle keeps the run brief: 500 ns is five cycles
   system_clock_source_select #(.SETTLE_NS(500)) DUT (
      .clock_in              (clock_in),
      .srst_in               (srst_in),
      .reg_req_in            (req),
      .fast_osc_pin_in       (fast_pin),
      .slow_osc_pin_in       (slow_pin),
      .rd_data_out           (rd_data_out),
      .fast_osc_run_out      (fast_osc_run_out),
      .fast_osc_freq_out     (fast_osc_freq_out),
      .fast_osc_stable_out   (fast_osc_stable_out),
      .system_clock_out      (system_clock_out),
      .fast_periph_clock_out (fast_periph_clock_out),
      .wdt_clock_out         (wdt_clock_out),
      .time_base_clock_out   (time_base_clock_out),
      .idle_fast_en_out      (idle_fast_en_out),
      .idle_slow_en_out      (idle_slow_en_out)
   );

   // ************************************************
   // clock, oscillator pins, timeout, glitch watch
   // ************************************************
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   // pins far slower than clock_in so sampling never aliases
   always @(posedge clock_in) begin
      pcnt <= pcnt + 1;
      if (pcnt % 4 == 3) fast_pin <= ~fast_pin;
      if (pcnt % 20 == 19) slow_pin <= ~slow_pin;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches++;
         end_sim();
      end
   end

   // high pulses never shorter than the fastest half period
   always @(negedge clock_in) begin
      if (system_clock_out === 1'b1) high_run <= high_run + 1;
      else begin
         if (glitch_mon && high_run > 0) check(high_run >= 4, 1'b1);
         high_run <= 0;
      end
   end

   // ************************************************
   // tasks
   // ************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock_in);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clock_in);
      req.wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock_in);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clock_in);
      req.rd <= 1'b0;
      #1 d = rd_data_out;
   endtask : rd_reg

   task automatic wait_stable(output int cnt);
      cnt = 0;
      while (fast_osc_stable_out !== 1'b1 && cnt < 100) begin
         @(posedge clock_in);
         #1 cnt++;
      end
      check(cnt < 100, 1'b1);
   endtask : wait_stable

   function automatic logic pick(input int w);
      case (w)
         0: pick = system_clock_out;
         1: pick = wdt_clock_out;
         2: pick = time_base_clock_out;
         default: pick = fast_periph_clock_out[0];
      endcase
   endfunction : pick

   // skips two rises so a hand-over settles, then counts one period
   task automatic measure(input int w, input int exp);
      int  cnt;
      logic p;
      for (int r = 0; r < 3; r++) begin
         cnt = 0;
         do begin
            p = pick(w);
            @(posedge clock_in);
            #1 cnt++;
         end while (!(p === 1'b0 && pick(w) === 1'b1) && cnt < 2000);
      end
      check(cnt, exp);
   endtask : measure

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      srst_in = 1'b1;
      req = '0;
      fast_pin = 1'b0;
      slow_pin = 1'b0;
      mismatches = 0;
      compares = 0;
      cycles = 0;
      pcnt = 0;
      high_run = 0;
      glitch_mon = 1'b0;
      rows = '{'{2'h0, 8'hFF, 8'hE3}, '{2'h0, 8'h1E, 8'h02}, '{2'h2, 8'hFF, 8'h01},
               '{2'h2, 8'h00, 8'h00}, '{2'h3, 8'hFF, 8'h00}, '{2'h1, 8'h0F, 8'h0D}};
      repeat (3) @(posedge clock_in);
      srst_in <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(rows[i].addr, rows[i].wdata);
         rd_reg(rows[i].addr, rd);
         check(rd, rows[i].rexp);
      end
      // reset values, flag clear and settle
      @(posedge clock_in);
      srst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      srst_in <= 1'b0;
      #1 check({fast_osc_run_out, fast_osc_freq_out, fast_osc_stable_out}, 4'h8);
      check({idle_fast_en_out, idle_slow_en_out, system_clock_out}, 3'h0);
      foreach (rows[i]) begin
         rd_reg(2'(i % 4), rd);
         check(rd, (i % 4 == 1) ? ((i < 4) ? 8'h01 : 8'h03) : 8'h00);
      end
      @(posedge clock_in);
      #1 check(rd_data_out, 8'h00);
      wait_stable(n);
      wr_reg(2'h1, 8'h05);
      @(posedge clock_in);
      #1 check(fast_osc_stable_out, 1'b0);
      wait_stable(n);
      check(n >= 3, 1'b1);
      for (int c = 0; c < 4; c++) begin
         wr_reg(2'h1, 8'(c * 4 + 1));
         @(posedge clock_in);
         wait_stable(n);
         check(fast_osc_freq_out, (c == 3) ? 2'h0 : 2'(c));
         rd_reg(2'h1, rd);
         check(rd, 8'(c * 4 + 3));
      end
      // every division, switched at run time
      glitch_mon = 1'b1;
      for (int k = 0; k < 7; k++) begin
         wr_reg(2'h0, 8'(k * 32));
         measure(0, 8 << k);
      end
      // slow source, watchdog and time base
      wr_reg(2'h0, 8'hE0);
      measure(0, 40);
      measure(1, 40);
      measure(2, 40);
      wr_reg(2'h2, 8'h01);
      measure(2, 512);
      glitch_mon = 1'b0;
      // fast oscillator stops or runs on its enable, and runs while the fast clock is selected
      wr_reg(2'h1, 8'h00);
      repeat (10) @(posedge clock_in);
      #1 check({fast_osc_run_out, fast_periph_clock_out}, 8'h00);
      wr_reg(2'h1, 8'h01);
      repeat (3) @(posedge clock_in);
      #1 check(fast_osc_run_out, 1'b1);
      wait_stable(n);
      measure(3, 8);
      wr_reg(2'h1, 8'h00);
      wr_reg(2'h0, 8'h00);
      repeat (3) @(posedge clock_in);
      #1 check(fast_osc_run_out, 1'b1);
      end_sim();
   end
endmodule : testbench
